// ===== power_control_pkg.sv
// Register map, field positions and carriers for the power control block
`default_nettype none
package power_control_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATE_OFFSET = 12'h004;

  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STATE_RESET = 32'h0000_0000;

  // Control register fields
  localparam int CTL_REG_LP_BIT = 0;
  localparam int CTL_TARGET_BIT = 1;
  localparam int CTL_WAKE_CLR_BIT = 2;
  localparam int CTL_SB_CLR_BIT = 3;
  localparam int CTL_DET_EN_BIT = 4;
  localparam int CTL_THR_LSB = 5;
  localparam int CTL_THR_MSB = 7;
  localparam int CTL_BKP_WE_BIT = 8;

  // State register fields
  localparam int STS_WAKE_BIT = 0;
  localparam int STS_SB_BIT = 1;
  localparam int STS_DET_BIT = 2;
  localparam int STS_PIN_EN_BIT = 8;

  // Cycles from a wake clear write to the flag dropping
  localparam int WAKE_CLR_DELAY = 2;

  // Threshold codes, 2.2 V to 2.9 V in 0.1 V steps
  typedef enum logic [2:0] {
    THR_2V2, THR_2V3, THR_2V4, THR_2V5,
    THR_2V6, THR_2V7, THR_2V8, THR_2V9
  } threshold_type;

  typedef struct packed {
    logic backup_write_enable;
    threshold_type detector_threshold_select;
    logic voltage_detector_enable;
    logic deepsleep_target_select;
    logic stop_regulator_lowpower;
  } control_type;

  typedef struct packed {
    logic wake_pin_enable;
    logic detector_output_flag;
    logic standby_entered_flag;
    logic wake_event_flag;
  } state_type;

  typedef struct packed {
    logic enter_stop;
    logic enter_standby;
  } sleep_req_type;

endpackage : power_control_pkg
`default_nettype wire

// ===== power_control_status_regs.sv
// Power control and status registers with an APB slave port
`default_nettype none
module power_control_status_regs (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [power_control_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [power_control_pkg::DATA_W-1:0] pwdata_i,
  output logic [power_control_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic wake_pin_i,
  input wire logic rtc_alarm_wake_i,
  input wire logic supply_below_i,
  input wire logic core_deep_sleep_bit_i,
  input wire logic sleep_instr_i,
  input wire logic standby_wakeup_i,
  output logic stop_regulator_lowpower_o,
  output logic voltage_detector_enable_o,
  output logic [2:0] detector_threshold_select_o,
  output logic backup_write_enable_o,
  output logic wake_pin_enable_o,
  output logic enter_stop_o,
  output logic enter_standby_o,
  output logic in_standby_o
);

  power_control_pkg::control_type ctrl_r;
  power_control_pkg::state_type sts_r;
  power_control_pkg::sleep_req_type req_r;
  logic [power_control_pkg::DATA_W-1:0] prdata_r;
  logic [power_control_pkg::WAKE_CLR_DELAY-1:0] wake_clr_pipe_r;
  logic [2:0] pin_sync_r;
  logic [2:0] below_sync_r;
  logic pin_level_r;
  logic below_level_r;
  logic standby_r;
  logic stretch_r;
  logic is_ctrl;
  logic is_sts;
  logic access;
  logic wr_ctrl;
  logic wr_sts;
  logic wake_set;
  logic wake_clr;
  logic sb_clr;
  logic sleep_ok;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign is_ctrl = paddr_i == power_control_pkg::CONTROL_OFFSET;
  assign is_sts = paddr_i == power_control_pkg::STATE_OFFSET;
  assign access = psel_i && penable_i;

  // Status read waits one cycle before completing
  assign pready_o = !(access && !pwrite_i && is_sts) || stretch_r;
  assign pslverr_o = access && !(is_ctrl || is_sts);
  assign wr_ctrl = access && pwrite_i && is_ctrl;
  assign wr_sts = access && pwrite_i && is_sts;
  assign prdata_o = prdata_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stretch_r <= 1'b0;
    end else begin
      stretch_r <= access && !pwrite_i && is_sts && !stretch_r;
    end
  end

  // Read data is registered each cycle of a read; the stretched status read
  // thus presents a sample taken in its first access cycle.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata_r <= '0;
    end else if (psel_i && !pwrite_i) begin
      prdata_r <= '0;
      if (is_ctrl) begin
        prdata_r[power_control_pkg::CTL_REG_LP_BIT] <=
          ctrl_r.stop_regulator_lowpower;
        prdata_r[power_control_pkg::CTL_TARGET_BIT] <=
          ctrl_r.deepsleep_target_select;
        prdata_r[power_control_pkg::CTL_DET_EN_BIT] <=
          ctrl_r.voltage_detector_enable;
        prdata_r[power_control_pkg::CTL_THR_MSB:power_control_pkg::CTL_THR_LSB]
          <= ctrl_r.detector_threshold_select;
        prdata_r[power_control_pkg::CTL_BKP_WE_BIT] <=
          ctrl_r.backup_write_enable;
      end else if (is_sts) begin
        prdata_r[power_control_pkg::STS_WAKE_BIT] <= sts_r.wake_event_flag;
        prdata_r[power_control_pkg::STS_SB_BIT] <= sts_r.standby_entered_flag;
        prdata_r[power_control_pkg::STS_DET_BIT] <= sts_r.detector_output_flag;
        prdata_r[power_control_pkg::STS_PIN_EN_BIT] <= sts_r.wake_pin_enable;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || standby_wakeup_i) begin
      // Cast only the bits the packed control fields occupy
      ctrl_r <= power_control_pkg::control_type'(power_control_pkg::CONTROL_RESET[
        $bits(power_control_pkg::control_type)-1:0]);
    end else if (wr_ctrl) begin
      ctrl_r.stop_regulator_lowpower <=
        pwdata_i[power_control_pkg::CTL_REG_LP_BIT];
      ctrl_r.deepsleep_target_select <=
        pwdata_i[power_control_pkg::CTL_TARGET_BIT];
      ctrl_r.voltage_detector_enable <=
        pwdata_i[power_control_pkg::CTL_DET_EN_BIT];
      ctrl_r.detector_threshold_select <= power_control_pkg::threshold_type'(
        pwdata_i[power_control_pkg::CTL_THR_MSB:
                 power_control_pkg::CTL_THR_LSB]);
      ctrl_r.backup_write_enable <=
        pwdata_i[power_control_pkg::CTL_BKP_WE_BIT];
    end
  end

  assign stop_regulator_lowpower_o = ctrl_r.stop_regulator_lowpower;
  assign voltage_detector_enable_o = ctrl_r.voltage_detector_enable;
  assign detector_threshold_select_o = ctrl_r.detector_threshold_select;
  assign backup_write_enable_o = ctrl_r.backup_write_enable;

  // Write-one clear pulses; the wake clear is delayed to match the part
  assign wake_clr = wake_clr_pipe_r[power_control_pkg::WAKE_CLR_DELAY-1];
  assign sb_clr = wr_ctrl && pwdata_i[power_control_pkg::CTL_SB_CLR_BIT];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wake_clr_pipe_r <= '0;
    end else begin
      wake_clr_pipe_r <= {wake_clr_pipe_r[power_control_pkg::WAKE_CLR_DELAY-2:0],
        wr_ctrl && pwdata_i[power_control_pkg::CTL_WAKE_CLR_BIT]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a level counts once stages two and three agree

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_sync_r <= '0;
      below_sync_r <= '0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], wake_pin_i};
      below_sync_r <= {below_sync_r[1:0], supply_below_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_level_r <= 1'b0;
      below_level_r <= 1'b0;
    end else begin
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_level_r <= pin_sync_r[2];
      end
      if (below_sync_r[1] == below_sync_r[2]) begin
        below_level_r <= below_sync_r[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status register; a set always wins over a simultaneous clear

  // Level sensitive: a pin held high keeps re-setting the flag
  assign wake_set = (sts_r.wake_pin_enable && pin_level_r)
    || rtc_alarm_wake_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sts_r <= power_control_pkg::state_type'(
        power_control_pkg::STATE_RESET[3:0]);
    end else begin
      if (wake_set) begin
        sts_r.wake_event_flag <= 1'b1;
      end else if (wake_clr) begin
        sts_r.wake_event_flag <= 1'b0;
      end
      if (req_r.enter_standby) begin
        sts_r.standby_entered_flag <= 1'b1;
      end else if (sb_clr) begin
        sts_r.standby_entered_flag <= 1'b0;
      end
      // Detector stops in standby, so its flag is forced low there
      sts_r.detector_output_flag <= ctrl_r.voltage_detector_enable
        && !standby_r && below_level_r;
      if (wr_sts) begin
        sts_r.wake_pin_enable <=
          pwdata_i[power_control_pkg::STS_PIN_EN_BIT];
      end
    end
  end

  assign wake_pin_enable_o = sts_r.wake_pin_enable;

  //////////////////////////////////////////////////////////////////////////
  // Deep sleep entry

  assign sleep_ok = sleep_instr_i && core_deep_sleep_bit_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_r <= '0;
    end else begin
      req_r.enter_standby <= sleep_ok && ctrl_r.deepsleep_target_select
        && !sts_r.wake_event_flag;
      req_r.enter_stop <= sleep_ok && !ctrl_r.deepsleep_target_select;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || standby_wakeup_i) begin
      standby_r <= 1'b0;
    end else if (req_r.enter_standby) begin
      standby_r <= 1'b1;
    end
  end

  assign enter_stop_o = req_r.enter_stop;
  assign enter_standby_o = req_r.enter_standby;
  assign in_standby_o = standby_r;

endmodule : power_control_status_regs
`default_nettype wire

// ===== power_control_props.sv
// Assertion checker for the power control register block
`default_nettype none
module power_control_props (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [power_control_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [power_control_pkg::DATA_W-1:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sleep_instr_i,
  input wire logic core_deep_sleep_bit_i,
  input wire logic standby_wakeup_i,
  input wire logic backup_write_enable_o,
  input wire logic voltage_detector_enable_o,
  input wire logic enter_stop_o,
  input wire logic enter_standby_o,
  input wire logic in_standby_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic acc;
  assign acc = psel_i && penable_i;
  sequence s_st_setup;
    psel_i && !penable_i && !pwrite_i && paddr_i == 12'h004;
  endsequence
  sequence s_one_wait;
    !pready_o ##1 pready_o;
  endsequence
  a_status_wait: assert property (s_st_setup |=> s_one_wait)
    else $error("status read wait state wrong");
  a_ctrl_ready: assert property (acc && paddr_i == 12'h000 |-> pready_o)
    else $error("control access stalled");
  a_bad_addr: assert property (acc && paddr_i != 12'h000 && paddr_i != 12'h004
    |-> pslverr_o)
    else $error("unmapped access without error");
  a_ctrl_write: assert property (acc && pwrite_i && paddr_i == 12'h000 &&
    !standby_wakeup_i |=> backup_write_enable_o == $past(pwdata_i[8]) &&
    voltage_detector_enable_o == $past(pwdata_i[4]))
    else $error("control write not applied");
  a_stop_cause: assert property (enter_stop_o |->
    $past(sleep_instr_i && core_deep_sleep_bit_i))
    else $error("stop entry without cause");
  a_sb_cause: assert property (enter_standby_o |->
    $past(sleep_instr_i && core_deep_sleep_bit_i))
    else $error("standby entry without cause");
  a_one_mode: assert property (!(enter_stop_o && enter_standby_o))
    else $error("stop and standby together");
  a_no_deep: assert property (sleep_instr_i && !core_deep_sleep_bit_i
    |=> !enter_stop_o && !enter_standby_o)
    else $error("deep sleep entry without deep bit");
  a_sb_level: assert property (enter_standby_o && !standby_wakeup_i
    |=> in_standby_o)
    else $error("standby level not set");
  a_wake_clear: assert property (standby_wakeup_i && !psel_i
    |=> !backup_write_enable_o && !voltage_detector_enable_o)
    else $error("control not cleared on wake");
endmodule : power_control_props
bind power_control_status_regs power_control_props u_props (.*);
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the power control register block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pin = 0, rtc = 0;
  logic below = 0, deep = 0, slp = 0, wku = 0, serr;
  logic rdy, err, lp, den, bwe, wpe, est, esb, isb;
  logic [2:0] thr;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0, rd, q;
  int fails = 0, total_checks = 0, cyc = 0, waits;
  power_control_status_regs u_dut (.core_clk_i(clk), .sys_rst_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr),
    .pwdata_i(wd), .prdata_o(rd), .pready_o(rdy), .pslverr_o(err),
    .wake_pin_i(pin), .rtc_alarm_wake_i(rtc), .supply_below_i(below),
    .core_deep_sleep_bit_i(deep), .sleep_instr_i(slp),
    .standby_wakeup_i(wku), .stop_regulator_lowpower_o(lp),
    .voltage_detector_enable_o(den), .detector_threshold_select_o(thr),
    .backup_write_enable_o(bwe), .wake_pin_enable_o(wpe),
    .enter_stop_o(est), .enter_standby_o(esb), .in_standby_o(isb));
  initial forever #5 clk = ~clk;
  task conclude;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Overall ceiling on run length; a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      fails++;
      conclude();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Request held until the edge that samples pready high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk); psel = 1; pwr = w; addr = a; wd = d;
    @(negedge clk); pen = 1; waits = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && waits < 8) begin
      waits++;
      @(posedge clk);
    end
    q = rd;
    serr = err;
    @(negedge clk); psel = 0; pen = 0;
  endtask : xfer
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task sleep_pulse(input logic es, input logic eb);
    @(negedge clk); slp = 1;
    @(negedge clk); slp = 0;
    chk("stop", {31'h0, es}, {31'h0, est});
    chk("stby", {31'h0, eb}, {31'h0, esb});
  endtask : sleep_pulse
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk); rst = 0;
    xfer(0, 12'h000, 0); chk("ctl", 0, q);
    chk("ctlw", 0, waits);
    xfer(0, 12'h004, 0); chk("sts", 0, q);
    chk("stsw", 1, waits);
    xfer(1, 12'h000, 32'hffff_ffff);
    xfer(0, 12'h000, 0); chk("rsv", 32'h0000_01f3, q);
    chk("outs", 32'h3f, {bwe, thr, den, lp});
    below = 1; idle(8);
    xfer(0, 12'h004, 0); chk("det", 1, q[2]);
    xfer(1, 12'h004, 32'h0000_0100); chk("wpe", 1, wpe);
    pin = 1; idle(8);
    xfer(0, 12'h004, 0); chk("pin", 1, q[0]);
    pin = 0; idle(8);
    xfer(1, 12'h000, 32'h0000_0004); idle(3);
    xfer(0, 12'h004, 0); chk("wclr", 0, q[0]);
    @(negedge clk); rtc = 1;
    @(negedge clk); rtc = 0;
    xfer(0, 12'h004, 0); chk("rtc", 1, q[0]);
    xfer(1, 12'h000, 32'h0000_0001); deep = 1;
    sleep_pulse(1, 0); chk("lp", 1, lp);
    xfer(1, 12'h000, 32'h0000_0012);
    sleep_pulse(0, 0);
    xfer(1, 12'h000, 32'h0000_0016); idle(4);
    sleep_pulse(0, 1);
    idle(1); chk("isb", 1, isb);
    xfer(0, 12'h004, 0); chk("sbst", 32'h0000_0102, q);
    @(negedge clk); wku = 1;
    @(negedge clk); wku = 0;
    xfer(0, 12'h000, 0); chk("wctl", 0, q);
    xfer(0, 12'h004, 0); chk("wsts", 32'h102, q & 32'hffff_fffb);
    xfer(1, 12'h000, 32'h0000_0008);
    xfer(0, 12'h004, 0); chk("sclr", 0, q[1]);
    xfer(0, 12'h008, 0); chk("err", 1, serr);
    chk("errd", 0, q);
    @(negedge clk); rst = 1;
    idle(2); rst = 0;
    chk("rwpe", 0, wpe);
    conclude();
  end
endmodule : testbench
`default_nettype wire
